// [rtl/erk_params.svh]
// Purpose: offsets, field positions, reset values and counts for the report / key-request block
// Assumes: byte offsets inside 512-byte structures, word index = byte offset / 4
// Notes: definitions only
`ifndef ERK_PARAMS_SVH
`define ERK_PARAMS_SVH

`define ERK_ALIGN_BYTES 512
`define ERK_WORDS 128
`define ERK_LAST_IDX 7'h7f
// word-address map of the register bus
`define ERK_REG_CTRL 10'h200
`define ERK_REG_CAPS 10'h201
`define ERK_REG_MACKEY0 10'h202
`define ERK_REG_MACKEY3 10'h205
`define ERK_REG_RESULT 10'h206
`define ERK_RGN_REPORT 2'h0
`define ERK_RGN_SOURCE 2'h1
`define ERK_RGN_TARGET 2'h2
`define ERK_RGN_KEYREQ 2'h3
// ctrl register bits
`define ERK_CTRL_REPORT 0
`define ERK_CTRL_KEYCHK 1
// report byte offsets
`define ERK_RPT_PSV 9'h000
`define ERK_RPT_EFS 9'h010
`define ERK_RPT_CFA 9'h014
`define ERK_RPT_RSV0_LO 9'h015
`define ERK_RPT_RSV0_HI 9'h020
`define ERK_RPT_MEAS 9'h040
`define ERK_RPT_RSV1_LO 9'h060
`define ERK_RPT_RSV1_HI 9'h080
`define ERK_RPT_SIGNER 9'h080
`define ERK_RPT_RSV2_LO 9'h0a0
`define ERK_RPT_RSV2_HI 9'h0c0
`define ERK_RPT_CFGID 9'h0c0
`define ERK_RPT_PROD 9'h100
`define ERK_RPT_ENCLAVE_SECURITY_VERSION 9'h102
`define ERK_RPT_CFGSVN 9'h104
`define ERK_RPT_RSV3_LO 9'h106
`define ERK_RPT_RSV3_HI 9'h130
`define ERK_RPT_USER 9'h140
`define ERK_RPT_WEAR 9'h180
`define ERK_RPT_MAC 9'h1a0
`define ERK_RPT_END 9'h1b0
`define ERK_MAC_IDX_LO 7'h68
`define ERK_MAC_IDX_HI 7'h6b
// target description byte offsets
`define ERK_TGT_MEAS 9'h000
`define ERK_TGT_ATTR 9'h020
`define ERK_TGT_CFA 9'h030
`define ERK_TGT_RSV49 9'h031
`define ERK_TGT_CFGSVN 9'h032
`define ERK_TGT_EFS 9'h034
`define ERK_TGT_RSV56_LO 9'h038
`define ERK_TGT_RSV56_HI 9'h040
`define ERK_TGT_TAIL 9'h080
// key request byte offsets
`define ERK_KRQ_SEL 9'h000
`define ERK_KRQ_POLICY 9'h002
`define ERK_KRQ_VER 9'h004
`define ERK_KRQ_CFMASK 9'h006
`define ERK_KRQ_RSV7 9'h007
`define ERK_KRQ_PSV 9'h008
`define ERK_KRQ_ATTRMASK 9'h018
`define ERK_KRQ_WEAR 9'h028
`define ERK_KRQ_FEATMASK 9'h048
`define ERK_KRQ_CFGSVN 9'h04c
`define ERK_KRQ_TAIL 9'h04e
// key selector values and policy layout
`define ERK_SEL_LAUNCH 16'h0000
`define ERK_SEL_PROV 16'h0001
`define ERK_SEL_PROV_SEAL 16'h0002
`define ERK_SEL_REPORT 16'h0003
`define ERK_SEL_SEAL 16'h0004
`define ERK_POLICY_RSV_MASK 16'hffc0
`define ERK_RESET_MACKEY 128'h0
`endif

// [rtl/erk_pkg.sv]
// Purpose: types of the report / key-request block
// Assumes: constants live in erk_params.svh
// Notes: state is one-hot
`default_nettype none
package erk_pkg;
  typedef enum logic [2:0] {
    ERK_IDLE = 3'b001,
    ERK_REPORT = 3'b010,
    ERK_KEYCHK = 3'b100
  } erk_state_t;

  typedef struct packed {
    erk_state_t state;
    logic [6:0] idx;
    logic waitreq;
    logic [31:0] readdata;
    logic caps;
    logic [127:0] mackey;
    logic [127:0] acc;
    logic fault;
    logic tgt_fault;
    logic rpt_ready;
    logic key_ok;
    logic key_bad;
    logic [15:0] sel;
    logic [15:0] policy;
    logic report_done;
    logic key_derive_valid;
    logic [2:0] key_derive_sel;
    logic key_fault;
  } erk_regs_t;
endpackage
`default_nettype wire

// [rtl/erk_engine.sv]
// Purpose: builds the report and checks key requests, reached over Avalon-MM
// Assumes: one clock, async active-low reset, software fills source/target/key areas
// Notes: the bus is held off while the engine runs
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`include "erk_params.svh"
`default_nettype none
module erk_engine
  import erk_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic report_done,
  output logic key_derive_valid,
  output logic [2:0] key_derive_sel,
  output logic key_fault
);

  logic [31:0] mem [0:511];
  erk_regs_t st;
  erk_regs_t next_st;
  logic mem_we;
  logic [8:0] mem_wa;
  logic [31:0] mem_wd;
  logic [3:0] mem_be;
  logic [31:0] src_word;
  logic [31:0] tgt_word;
  logic [31:0] krq_word;
  logic [31:0] bus_word;
  logic [127:0] mac;
  logic [31:0] rpt_w;
  logic word_fault;
  logic bus_take;
  logic start_rpt;
  logic start_key;

  // reserved bytes of each structure, per byte offset
  function automatic logic byte_rsv(input logic [1:0] rgn, input logic [8:0] b, input logic caps);
    logic r;
    r = 1'b0;
    unique case (rgn)
      `ERK_RGN_REPORT: begin
        r = (b >= `ERK_RPT_RSV0_LO && b < `ERK_RPT_RSV0_HI) || (b >= `ERK_RPT_RSV1_LO && b < `ERK_RPT_RSV1_HI) ||
            (b >= `ERK_RPT_RSV2_LO && b < `ERK_RPT_RSV2_HI) || (b >= `ERK_RPT_RSV3_LO && b < `ERK_RPT_RSV3_HI) ||
            (b == `ERK_RPT_CFA && !caps) || b >= `ERK_RPT_END;
      end
      `ERK_RGN_TARGET: begin
        r = b == `ERK_TGT_RSV49 || (b >= `ERK_TGT_RSV56_LO && b < `ERK_TGT_RSV56_HI) ||
            (b == `ERK_TGT_CFA && !caps) || b >= `ERK_TGT_TAIL;
      end
      `ERK_RGN_KEYREQ: begin
        // fields up to byte 77 stay live, byte 6 only with capability
        r = b == `ERK_KRQ_RSV7 || (b == `ERK_KRQ_CFMASK && !caps) || b >= `ERK_KRQ_TAIL;
      end
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // per-byte mask of a word: ones where the byte is reserved
  function automatic logic [31:0] rsv_mask(input logic [1:0] rgn, input logic [6:0] idx, input logic caps);
    logic [31:0] m;
    m = 32'h0;
    for (int k = 0; k < 4; k++) begin
      if (byte_rsv(rgn, {idx, k[1:0]}, caps)) begin
        m[k*8 +: 8] = 8'hff;
      end
    end
    return m;
  endfunction

  // mixing step of the running authentication value
  function automatic logic [127:0] mix(input logic [127:0] a, input logic [31:0] w);
    return {a[126:0], a[127]} ^ {a[31:0], w, ~w, w};
  endfunction

  // which word index holds a byte offset
  function automatic logic [6:0] widx(input logic [8:0] off);
    return off[8:2];
  endfunction

  assign src_word = mem[{`ERK_RGN_SOURCE, st.idx}];
  assign tgt_word = mem[{`ERK_RGN_TARGET, st.idx}];
  assign krq_word = mem[{`ERK_RGN_KEYREQ, st.idx}];
  assign bus_word = mem[avs_address[8:0]];
  assign mac = st.acc ^ st.mackey;
  // copies processor version, feature vector, measurements, config ident, idents, payload, wear-out
  assign rpt_w = src_word & ~rsv_mask(`ERK_RGN_REPORT, st.idx, st.caps);
  assign bus_take = (avs_read || avs_write) && !st.waitreq;
  assign start_rpt = bus_take && avs_write && avs_address == `ERK_REG_CTRL && avs_byteenable[0] &&
                     avs_writedata[`ERK_CTRL_REPORT];
  assign start_key = bus_take && avs_write && avs_address == `ERK_REG_CTRL && avs_byteenable[0] &&
                     avs_writedata[`ERK_CTRL_KEYCHK] && !avs_writedata[`ERK_CTRL_REPORT];

  // fault of the key request word under scan
  always_comb begin
    word_fault = (krq_word & rsv_mask(`ERK_RGN_KEYREQ, st.idx, st.caps)) != 32'h0;
    if (st.idx == widx(`ERK_KRQ_SEL)) begin
      // selector above the seal key is reserved; policy high bits must be zero
      if (krq_word[15:0] > `ERK_SEL_SEAL || (krq_word[31:16] & `ERK_POLICY_RSV_MASK) != 16'h0) begin
        word_fault = 1'b1;
      end
    end
  end

  // memory write port: report area by the engine, other areas by the bus when idle
  always_comb begin
    mem_we = 1'b0;
    mem_wa = avs_address[8:0];
    mem_wd = avs_writedata;
    mem_be = avs_byteenable;
    if (st.state == ERK_REPORT) begin
      mem_we = 1'b1;
      mem_wa = {`ERK_RGN_REPORT, st.idx};
      mem_be = 4'hf;
      if (st.idx >= `ERK_MAC_IDX_LO && st.idx <= `ERK_MAC_IDX_HI) begin
        mem_wd = mac[(st.idx - `ERK_MAC_IDX_LO) * 32 +: 32];
      end else begin
        mem_wd = rpt_w;
      end
    end else if (bus_take && avs_write && !avs_address[9] && avs_address[8:7] != `ERK_RGN_REPORT) begin
      mem_we = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      for (int k = 0; k < 4; k++) begin
        if (mem_be[k]) begin
          mem[mem_wa][k*8 +: 8] <= mem_wd[k*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.report_done = 1'b0;
    next_st.key_derive_valid = 1'b0;
    next_st.key_fault = 1'b0;
    next_st.waitreq = 1'b1;
    // bus slave: one wait cycle, answer while idle only
    if ((avs_read || avs_write) && st.waitreq && st.state == ERK_IDLE) begin
      next_st.waitreq = 1'b0;
      next_st.readdata = 32'h0;
      if (avs_read) begin
        if (!avs_address[9]) begin
          next_st.readdata = bus_word;
        end else if (avs_address == `ERK_REG_CTRL) begin
          next_st.readdata = {27'h0, st.tgt_fault, st.key_bad, st.key_ok, st.rpt_ready, 1'b0};
        end else if (avs_address == `ERK_REG_CAPS) begin
          next_st.readdata = {31'h0, st.caps};
        end else if (avs_address >= `ERK_REG_MACKEY0 && avs_address <= `ERK_REG_MACKEY3) begin
          next_st.readdata = 32'h0;
        end else if (avs_address == `ERK_REG_RESULT) begin
          next_st.readdata = {st.policy, st.sel};
        end
      end
    end
    if (bus_take && avs_write) begin
      if (avs_address == `ERK_REG_CAPS && avs_byteenable[0]) begin
        next_st.caps = avs_writedata[0];
      end
      for (int k = 0; k < 4; k++) begin
        if (avs_address == `ERK_REG_MACKEY0 + 10'(k)) begin
          for (int b = 0; b < 4; b++) begin
            if (avs_byteenable[b]) begin
              next_st.mackey[k*32 + b*8 +: 8] = avs_writedata[b*8 +: 8];
            end
          end
        end
      end
    end
    unique case (st.state)
      ERK_IDLE: begin
        if (start_rpt) begin
          next_st.state = ERK_REPORT;
          next_st.idx = 7'h0;
          next_st.acc = 128'h0;
          next_st.tgt_fault = 1'b0;
          next_st.rpt_ready = 1'b0;
        end else if (start_key) begin
          next_st.state = ERK_KEYCHK;
          next_st.idx = 7'h0;
          next_st.fault = 1'b0;
          next_st.key_ok = 1'b0;
          next_st.key_bad = 1'b0;
        end
      end
      ERK_REPORT: begin
        if (st.idx < `ERK_MAC_IDX_LO) begin
          next_st.acc = mix(st.acc, rpt_w);
        end
        // target tail and reserved bytes must be clear; flagged, report still built
        if ((tgt_word & rsv_mask(`ERK_RGN_TARGET, st.idx, st.caps)) != 32'h0) begin
          next_st.tgt_fault = 1'b1;
        end
        next_st.idx = st.idx + 7'h1;
        if (st.idx == `ERK_LAST_IDX) begin
          next_st.state = ERK_IDLE;
          next_st.rpt_ready = 1'b1;
          next_st.report_done = 1'b1;
        end
      end
      ERK_KEYCHK: begin
        next_st.fault = st.fault | word_fault;
        if (st.idx == widx(`ERK_KRQ_SEL)) begin
          next_st.sel = krq_word[15:0];
          next_st.policy = krq_word[31:16];
        end
        next_st.idx = st.idx + 7'h1;
        if (st.idx == `ERK_LAST_IDX) begin
          next_st.state = ERK_IDLE;
          if (st.fault || word_fault) begin
            next_st.key_fault = 1'b1;
            next_st.key_bad = 1'b1;
          end else begin
            next_st.key_derive_valid = 1'b1;
            next_st.key_derive_sel = st.sel[2:0];
            next_st.key_ok = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '{state: ERK_IDLE, idx: 7'h0, waitreq: 1'b1, readdata: 32'h0, caps: 1'b0,
              mackey: `ERK_RESET_MACKEY, acc: 128'h0, fault: 1'b0, tgt_fault: 1'b0, rpt_ready: 1'b0,
              key_ok: 1'b0, key_bad: 1'b0, sel: 16'h0, policy: 16'h0, report_done: 1'b0,
              key_derive_valid: 1'b0, key_derive_sel: 3'h0, key_fault: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitreq;
  assign report_done = st.report_done;
  assign key_derive_valid = st.key_derive_valid;
  assign key_derive_sel = st.key_derive_sel;
  assign key_fault = st.key_fault;

  // checks
  sequence s_report_walk;
    (st.state == ERK_REPORT) [*8];
  endsequence

  property p_report_len;
    @(posedge clk) disable iff (!resetn) start_rpt |=> s_report_walk ##121 report_done;
  endproperty
  a_report_len: assert property (p_report_len) else $error("report not done 129 cycles after start");

  property p_report_area;
    @(posedge clk) disable iff (!resetn) (st.state == ERK_REPORT) |-> mem_we && mem_wa[8:7] == `ERK_RGN_REPORT;
  endproperty
  a_report_area: assert property (p_report_area) else $error("report written outside its area");

  property p_mac_word;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_REPORT && st.idx == `ERK_MAC_IDX_LO) |-> mem_wd == (st.acc[31:0] ^ st.mackey[31:0]);
  endproperty
  a_mac_word: assert property (p_mac_word) else $error("authentication code word wrong");

  property p_payload_copy;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_REPORT && st.idx == widx(`ERK_RPT_USER)) |-> mem_wd == src_word;
  endproperty
  a_payload_copy: assert property (p_payload_copy) else $error("user payload not copied");

  property p_cfa_zero;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_REPORT && st.idx == widx(`ERK_RPT_CFA) && !st.caps) |-> mem_wd == 32'h0;
  endproperty
  a_cfa_zero: assert property (p_cfa_zero) else $error("control-flow byte not zero");

  property p_meas_copy;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_REPORT && (st.idx == widx(`ERK_RPT_MEAS) || st.idx == widx(`ERK_RPT_SIGNER)))
      |-> mem_wd == src_word;
  endproperty
  a_meas_copy: assert property (p_meas_copy) else $error("measurement not copied");

  property p_ident_copy;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_REPORT && st.idx == widx(`ERK_RPT_PROD)) |-> mem_wd == src_word;
  endproperty
  a_ident_copy: assert property (p_ident_copy) else $error("product ident or version not copied");

  property p_psv_copy;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_REPORT && (st.idx == widx(`ERK_RPT_PSV) || st.idx == widx(`ERK_RPT_EFS))) |-> mem_wd == src_word;
  endproperty
  a_psv_copy: assert property (p_psv_copy) else $error("processor version or feature vector not copied");

  property p_cfgid_copy;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_REPORT && st.idx == widx(`ERK_RPT_CFGID)) |-> mem_wd == src_word;
  endproperty
  a_cfgid_copy: assert property (p_cfgid_copy) else $error("configuration ident not copied");

  property p_wear_copy;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_REPORT && st.idx == widx(`ERK_RPT_WEAR)) |-> mem_wd == src_word;
  endproperty
  a_wear_copy: assert property (p_wear_copy) else $error("wear-out value not copied");

  property p_sel_fault;
    @(posedge clk) disable iff (!resetn)
      (st.state == ERK_KEYCHK && st.idx == `ERK_LAST_IDX && st.sel > `ERK_SEL_SEAL) |=> key_fault && !key_derive_valid;
  endproperty
  a_sel_fault: assert property (p_sel_fault) else $error("reserved selector not refused");

  property p_key_exclusive;
    @(posedge clk) disable iff (!resetn) key_derive_valid |-> !key_fault && $past(st.state) == ERK_KEYCHK;
  endproperty
  a_key_exclusive: assert property (p_key_exclusive) else $error("key granted outside check");

  property p_bus_answer;
    @(posedge clk) disable iff (!resetn)
      ((avs_read || avs_write) && st.waitreq && st.state == ERK_IDLE) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer not one cycle");

endmodule
`default_nettype wire

// [testbench/erk_sw_model.sv]
// Purpose: enclave software side, issues Avalon-MM cycles into the block
// Assumes: one clock, request held until waitrequest is seen low
// Notes: released address and data lines show the inverse of the last value
`default_nettype none
module erk_sw_model (
  input wire logic clk,
  input wire logic avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  output logic [9:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  timeunit 1ns;
  timeprecision 100ps;
  int bus_timeouts;
  initial begin
    bus_timeouts = 0;
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  // structure areas are whole 512-byte blocks at fixed bases
  task automatic access(input logic rd, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= ~rd;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    // longest legal hold-off is one engine run plus the answer cycle
    if (n > 200) begin
      bus_timeouts++;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: self-checking bench for report build and key-request checks
// Assumes: register map and timing of the block hand-over
// Notes: expected report words derived from the source image and mask rules
`include "erk_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic resetn;
  wire logic [9:0] avs_address;
  wire logic avs_read;
  wire logic avs_write;
  wire logic [31:0] avs_writedata;
  wire logic [3:0] avs_byteenable;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest;
  wire logic report_done;
  wire logic key_derive_valid;
  wire logic [2:0] key_derive_sel;
  wire logic key_fault;
  int fails;
  int total_checks;
  logic [31:0] src [128];
  logic [31:0] q;
  localparam logic [127:0] MACKEY_VAL = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  erk_engine u_dut (.clk(clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .report_done(report_done),
    .key_derive_valid(key_derive_valid), .key_derive_sel(key_derive_sel), .key_fault(key_fault));
  erk_sw_model u_sw (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_sw.access(1'b0, a, d, r);
  endtask
  task automatic rd(input logic [9:0] a, output logic [31:0] r);
    u_sw.access(1'b1, a, 32'h0, r);
  endtask
  function automatic logic [9:0] ad(input logic [1:0] rgn, input int i);
    return {1'b0, rgn, 7'(i)};
  endfunction
  // reserved report bytes below byte 416, byte 20 only without capability
  function automatic logic rsv(input int b, input logic caps);
    return (b >= 21 && b < 32) || (b >= 96 && b < 128) || (b >= 160 && b < 192) ||
      (b >= 262 && b < 304) || (b == 20 && !caps);
  endfunction
  task automatic wait_evt(output logic [2:0] ev);
    int n;
    n = 0;
    ev = 3'b000;
    while (ev === 3'b000 && n < 400) begin
      @(posedge clk);
      #1;
      ev = {report_done, key_derive_valid, key_fault};
      n++;
    end
  endtask
  task automatic check_report(input logic caps);
    logic [127:0] acc;
    logic [31:0] w;
    logic [31:0] r;
    logic [2:0] ev;
    wr(`ERK_REG_CAPS, {31'h0, caps});
    wr(`ERK_REG_CTRL, 32'h1);
    wait_evt(ev);
    chk(32'(ev), 32'h4, "report done pulse");
    acc = 128'h0;
    for (int i = 0; i < 128; i++) begin
      w = (i < 104) ? src[i] : 32'h0;
      for (int k = 0; k < 4; k++) begin
        if (rsv(4 * i + k, caps)) begin
          w[8 * k +: 8] = 8'h00;
        end
      end
      if (i < 104) begin
        acc = {acc[126:0], acc[127]} ^ {acc[31:0], w, ~w, w};
      end
      if (i >= 104 && i < 108) begin
        w = acc[32 * (i - 104) +: 32] ^ MACKEY_VAL[32 * (i - 104) +: 32];
      end
      rd(ad(`ERK_RGN_REPORT, i), r);
      chk(r, w, "report word");
    end
  endtask
  task automatic key_case(input logic caps, input logic [31:0] w0, input logic [31:0] w1, input int xi,
    input logic [31:0] xv, input logic ok);
    logic [2:0] ev;
    logic [31:0] r;
    wr(`ERK_REG_CAPS, {31'h0, caps});
    wr(ad(`ERK_RGN_KEYREQ, 0), w0);
    wr(ad(`ERK_RGN_KEYREQ, 1), w1);
    wr(ad(`ERK_RGN_KEYREQ, xi), xv);
    wr(`ERK_REG_CTRL, 32'h2);
    wait_evt(ev);
    chk(32'(ev), ok ? 32'h2 : 32'h1, "key outcome pulse");
    if (ok) begin
      chk(32'(key_derive_sel), w0 & 32'h7, "key selector out");
    end
    rd(`ERK_REG_RESULT, r);
    chk(r, w0, "selector and policy");
    rd(`ERK_REG_CTRL, r);
    chk(r & 32'hc, ok ? 32'h4 : 32'h8, "key status");
    wr(ad(`ERK_RGN_KEYREQ, xi), 32'h0);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    finish_test;
  end
  initial begin
    fails = 0;
    total_checks = 0;
    resetn = 1'b0;
    for (int i = 0; i < 128; i++) begin
      src[i] = {8'(i), 8'(i) ^ 8'h5a, ~8'(i), 8'h81};
    end
    repeat (3) @(posedge clk);
    chk(32'({avs_waitrequest, report_done, key_derive_valid, key_fault, key_derive_sel}), 32'h40, "reset");
    resetn <= 1'b1;
    for (int i = 0; i < 128; i++) begin
      wr(ad(`ERK_RGN_SOURCE, i), src[i]);
      wr(ad(`ERK_RGN_TARGET, i), 32'h0);
      wr(ad(`ERK_RGN_KEYREQ, i), 32'h0);
    end
    for (int k = 0; k < 4; k++) begin
      wr(10'(`ERK_REG_MACKEY0 + k), MACKEY_VAL[32 * k +: 32]);
    end
    wr(ad(`ERK_RGN_TARGET, 0), 32'hdeadbeef);
    wr(ad(`ERK_RGN_TARGET, 8), 32'h12345678);
    wr(ad(`ERK_RGN_TARGET, 12), 32'habcd0011);
    wr(ad(`ERK_RGN_TARGET, 13), 32'h87654321);
    check_report(1'b1);
    rd(`ERK_REG_CTRL, q);
    chk(q & 32'h12, 32'h02, "clean target status");
    wr(ad(`ERK_RGN_TARGET, 12), 32'habcd2200);
    check_report(1'b0);
    rd(`ERK_REG_CTRL, q);
    chk(q & 32'h12, 32'h12, "target reserved status");
    wr(ad(`ERK_RGN_REPORT, 3), 32'hffffffff);
    rd(ad(`ERK_RGN_REPORT, 3), q);
    chk(q, src[3], "report area read only");
    wr(10'h3ff, 32'h1);
    rd(10'h3ff, q);
    chk(q, 32'h0, "unmapped read");
    rd(`ERK_REG_MACKEY3, q);
    chk(q, 32'h0, "key register write only");
    for (int s = 0; s < 8; s++) begin
      key_case(1'b1, {16'h003f, 16'(s)}, 32'h5, 2, 32'h12345678, s <= 4);
    end
    key_case(1'b1, 32'h00400003, 32'h5, 2, 32'h0, 1'b0);
    key_case(1'b1, 32'h3, 32'h01000005, 2, 32'h0, 1'b0);
    key_case(1'b1, 32'h3, 32'h00110005, 6, 32'h9, 1'b1);
    key_case(1'b0, 32'h4, 32'h00110005, 10, 32'h9, 1'b0);
    key_case(1'b1, 32'h2, 32'h5, 10, 32'hffffffff, 1'b1);
    key_case(1'b1, 32'h1, 32'h5, 18, 32'hffffffff, 1'b1);
    key_case(1'b1, 32'h0, 32'h5, 19, 32'h0000ffff, 1'b1);
    key_case(1'b1, 32'h4, 32'h5, 19, 32'h00010000, 1'b0);
    key_case(1'b1, 32'h3, 32'h5, 127, 32'h80000000, 1'b0);
    chk(32'(u_sw.bus_timeouts), 32'h0, "bus answered");
    finish_test;
  end
endmodule
`default_nettype wire
